// ==== inc/sap_pkg.sv ====
// Shared constants and carrier types of the converter control and port.
// Assumes one 100 MHz core clock and asynchronous pins from the host.
`default_nettype none
package sap_pkg;
	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int RESULT_W = 18;
	localparam int IDX_W = 5;
	localparam int SYNC_STAGES = 3;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 20;
	localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 8;
	localparam logic [IDX_W-1:0] LAST_BIT = 5'h11;
	localparam logic [IDX_W-1:0] SER_BITS = 5'h12;
	// ----------------------------------------------------------------
	// Interface mode codes {bit1, bit0}
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_PAR18 = 2'h0;
	localparam logic [1:0] MODE_PAR16 = 2'h1;
	localparam logic [1:0] MODE_PAR8 = 2'h2;
	localparam logic [1:0] MODE_SERIAL = 2'h3;
	// ----------------------------------------------------------------
	// Pin input slot positions in the synchroniser vector
	// ----------------------------------------------------------------
	localparam int PIN_CNV = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_RD = 2;
	localparam int PIN_SCLK = 3;
	localparam int PIN_N = 4;
	// Serial clock resets low, its idle level, so no false fall follows reset
	localparam logic [PIN_N-1:0] PIN_RESET = 4'h7;
	typedef struct packed {
		logic serialClk;
		logic readN;
		logic chipSelectN;
		logic conversionStartN;
	} sap_pins_t;
	typedef struct packed {
		logic [1:0] interfaceSelect;
		logic outputCodingSelect;
		logic devicePowerDown;
		logic referencePowerDown;
		logic refBufferPowerDown;
	} sap_cfg_t;
	typedef struct packed {
		logic referenceOn;
		logic bufferOn;
		logic coreActive;
	} sap_power_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONVERT = 3'h2,
		ST_STORE = 3'h4
	} sap_state_t;
endpackage : sap_pkg
`default_nettype wire

// ==== core/sap_fifo.sv ====
// Result FIFO between the converter core and the output port.
// Assumes both sides on core_clk; pop side may stall indefinitely.
`default_nettype none
module sap_fifo import sap_pkg::*; #(
	parameter int WIDTH = RESULT_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
	} sap_fifo_state_t;
	sap_fifo_state_t st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;
	assign inReady = (st.count != DEPTH[AW:0]);
	assign outValid = (st.count != '0);
	assign outData = mem[st.rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	always_comb begin
		next_st = st;
		if (push)
			next_st.wrPtr = AW'(st.wrPtr + 1'b1);
		if (pop)
			next_st.rdPtr = AW'(st.rdPtr + 1'b1);
		if (push && !pop)
			next_st.count = (AW+1)'(st.count + 1'b1);
		else if (pop && !push)
			next_st.count = (AW+1)'(st.count - 1'b1);
	end
	always_ff @(posedge core_clk) begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
		if (push)
			mem[st.wrPtr] <= inData;
	end
endmodule : sap_fifo
`default_nettype wire

// ==== core/sap_converter.sv ====
// Conversion control and parallel/serial output port of the converter.
// Assumes host pins are asynchronous and the comparator decision is
// stable on core_clk when each bit trial is sampled.
//
// What this block does
// - A started conversion always completes; new starts and power-down cannot abort it.
// - Conversion start acts regardless of chip select and read strobe.
// - Chip select or read strobe high puts all data outputs in high impedance.
// - Chip select low with read strobe low drives the result onto the bus.
// - Coding select picks binary or two's complement, except in 18-bit mode.
// - Parallel port supports 18, 16 or 8 bit widths by mode inputs.
// - Result readable after conversion, in acquisition, or during the next conversion.
// - Serial output shares the parallel data bus pins.
// - Both mode inputs high selects the serial interface.
// - Serial mode shifts 18 bits out, MSB first, one per clock pulse.
// - Each serial bit holds across both clock edges of its pulse.
// - Both reference power-down inputs low run reference and buffer.
// - Reference power-down only powers the reference down, buffer stays on.
// - Both inputs high power down reference and buffer.
// - Reference and buffer power do not follow the main power-down input.
// - End of approximation produces the code and drops busy.
`default_nettype none
module sap_converter import sap_pkg::*; #(
	parameter int BIT_WAIT = BIT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire sap_pins_t pins,
	input wire sap_cfg_t cfg,
	input wire logic comparatorHigh,
	output logic busy,
	output logic [RESULT_W-1:0] dataBus,
	output logic [RESULT_W-1:0] dataBusOeN,
	output sap_power_t power
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [RESULT_W-1:0] applyCoding(
		input logic [RESULT_W-1:0] w,
		input logic binary
	);
		applyCoding = binary ? w : {~w[RESULT_W-1], w[RESULT_W-2:0]};
	endfunction : applyCoding

	function automatic logic [RESULT_W-1:0] busImage(
		input logic [RESULT_W-1:0] w,
		input logic [1:0] mode,
		input logic [1:0] phase,
		input logic [IDX_W-1:0] serIdx
	);
		logic [RESULT_W-1:0] img;
		img = '0;
		if (mode == MODE_PAR18) begin
			img = w;
		end else if (mode == MODE_PAR16) begin
			if (phase == 2'h0)
				img[15:0] = w[17:2];
			else
				img[15:0] = {w[1:0], 14'h0000};
		end else if (mode == MODE_PAR8) begin
			if (phase == 2'h0)
				img[7:0] = w[17:10];
			else if (phase == 2'h1)
				img[7:0] = w[9:2];
			else
				img[7:0] = {w[1:0], 6'h00};
		end else begin
			// Serial bit rides on bus bit 0, no pin of its own
			if (serIdx < SER_BITS)
				img[0] = w[LAST_BIT - serIdx];
		end
		busImage = img;
	endfunction : busImage

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PIN_N-1:0] sync1;
		logic [PIN_N-1:0] sync2;
		logic [PIN_N-1:0] sync3;
		logic [PIN_N-1:0] filt;
		sap_state_t state;
		logic [RESULT_W-1:0] sar;
		logic [IDX_W-1:0] bitIdx;
		logic [7:0] waitCnt;
		logic [RESULT_W-1:0] outWord;
		logic [1:0] phase;
		logic [IDX_W-1:0] serIdx;
		logic busy;
		logic [RESULT_W-1:0] bus;
		logic [RESULT_W-1:0] oeN;
		sap_power_t power;
	} sap_core_state_t;
	sap_core_state_t st, next_st;

	logic [PIN_N-1:0] pinVec;
	logic [PIN_N-1:0] filtNext;
	logic startEdge, rdRise, sclkFall, portSel, portIdle;
	logic pushReady, popValid, popReady;
	logic [RESULT_W-1:0] popData, coded, busWord;
	logic binaryCoding;

	assign pinVec = {pins.serialClk, pins.readN, pins.chipSelectN,
		pins.conversionStartN};
	// Filter kept outside the next-state process to avoid a feedback path
	for (genvar g = 0; g < PIN_N; g++) begin : gFilt
		assign filtNext[g] = (st.sync2[g] == st.sync3[g]) ?
			st.sync3[g] : st.filt[g];
	end
	assign startEdge = st.filt[PIN_CNV] && !filtNext[PIN_CNV];
	assign rdRise = !st.filt[PIN_RD] && filtNext[PIN_RD];
	assign sclkFall = st.filt[PIN_SCLK] && !filtNext[PIN_SCLK];
	assign portSel = !st.filt[PIN_CS] && !st.filt[PIN_RD];
	assign portIdle = st.filt[PIN_CS] || st.filt[PIN_RD];
	// Coding select has no effect in the full-width parallel mode
	assign binaryCoding = (cfg.interfaceSelect == MODE_PAR18) ||
		cfg.outputCodingSelect;
	assign coded = applyCoding(st.outWord, binaryCoding);
	assign busWord = busImage(coded, cfg.interfaceSelect, st.phase,
		st.serIdx);
	// New results only land while the port is quiet, so a read in progress
	// keeps the previous word; finished results wait in the FIFO meanwhile
	assign popReady = portIdle && !rdRise;

	sap_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) resultFifo (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(st.state == ST_STORE),
		.inReady(pushReady),
		.inData(st.sar),
		.outValid(popValid),
		.outReady(popReady),
		.outData(popData)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sync1 = pinVec;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		next_st.filt = filtNext;
		case (st.state)
			ST_IDLE: begin
				// Power-down only blocks new launches, never a running one
				if (startEdge && !cfg.devicePowerDown) begin
					next_st.state = ST_CONVERT;
					next_st.busy = 1'b1;
					next_st.sar = {1'b1, {(RESULT_W-1){1'b0}}};
					next_st.bitIdx = '0;
					next_st.waitCnt = 8'(BIT_WAIT - 1);
				end
			end
			ST_CONVERT: begin
				// Further starts and power-down are ignored here
				if (st.waitCnt != 8'h00) begin
					next_st.waitCnt = 8'(st.waitCnt - 1'b1);
				end else begin
					next_st.sar[LAST_BIT - st.bitIdx] = comparatorHigh;
					next_st.waitCnt = 8'(BIT_WAIT - 1);
					if (st.bitIdx == LAST_BIT) begin
						next_st.state = ST_STORE;
					end else begin
						next_st.bitIdx = IDX_W'(st.bitIdx + 1'b1);
						next_st.sar[LAST_BIT - st.bitIdx - 1'b1] = 1'b1;
					end
				end
			end
			ST_STORE: begin
				// Busy holds until the FIFO accepts the code
				if (pushReady) begin
					next_st.state = ST_IDLE;
					next_st.busy = 1'b0;
				end
			end
			default: begin
				next_st.state = ST_IDLE;
				next_st.busy = 1'b0;
			end
		endcase
		if (popValid && popReady) begin
			next_st.outWord = popData;
			next_st.phase = 2'h0;
		end else if (rdRise && !st.filt[PIN_CS]) begin
			if ((cfg.interfaceSelect == MODE_PAR16 && st.phase == 2'h0) ||
				(cfg.interfaceSelect == MODE_PAR8 && st.phase != 2'h2))
				next_st.phase = 2'(st.phase + 1'b1);
			else
				next_st.phase = 2'h0;
		end
		// Next bit launched on the falling edge, so it stays put across the
		// rising edge, which is where the host model samples each bit
		if (!portSel)
			next_st.serIdx = '0;
		else if (sclkFall && st.serIdx < SER_BITS)
			next_st.serIdx = IDX_W'(st.serIdx + 1'b1);
		next_st.bus = busWord;
		next_st.oeN = portSel ? '0 : '1;
		next_st.power.referenceOn = !cfg.referencePowerDown;
		next_st.power.bufferOn = !cfg.refBufferPowerDown;
		next_st.power.coreActive = !cfg.devicePowerDown || st.busy;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
			st.sync1 <= PIN_RESET;
			st.sync2 <= PIN_RESET;
			st.sync3 <= PIN_RESET;
			st.filt <= PIN_RESET;
			st.state <= ST_IDLE;
			st.oeN <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign dataBus = st.bus;
	assign dataBusOeN = st.oeN;
	assign power = st.power;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_convert_no_abort: assert property (@(posedge core_clk) disable iff (rst)
		(st.state == ST_CONVERT && st.waitCnt != 8'h00) |=>
		st.state == ST_CONVERT && st.busy)
		else $error("conversion left early");
	chk_start_ignores_port: assert property (@(posedge core_clk) disable iff (rst)
		(st.state == ST_IDLE && startEdge && !cfg.devicePowerDown) |=>
		st.busy && st.sar[RESULT_W-1])
		else $error("start edge not taken");
	chk_bus_released: assert property (@(posedge core_clk) disable iff (rst)
		(st.filt[PIN_CS] || st.filt[PIN_RD]) |=> dataBusOeN == '1)
		else $error("bus driven while deselected");
	chk_bus_driven: assert property (@(posedge core_clk) disable iff (rst)
		portSel |=> dataBusOeN == '0)
		else $error("bus not driven while read");
	chk_full_binary: assert property (@(posedge core_clk) disable iff (rst)
		(cfg.interfaceSelect == MODE_PAR18 && $stable(st.outWord)) |=>
		dataBus == $past(st.outWord))
		else $error("18-bit mode not straight binary");
	chk_serial_msb: assert property (@(posedge core_clk) disable iff (rst)
		(cfg.interfaceSelect == MODE_SERIAL && st.serIdx == 5'h00) |=>
		dataBus[0] == $past(coded[RESULT_W-1]) && dataBus[17:1] == '0)
		else $error("serial MSB not first");
	chk_serial_hold: assert property (@(posedge core_clk) disable iff (rst)
		(portSel && !sclkFall && st.serIdx != 5'h00) |=>
		$stable(st.serIdx))
		else $error("serial bit moved off launch edge");
	chk_ref_control: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> power.referenceOn == !$past(cfg.referencePowerDown) &&
		power.bufferOn == !$past(cfg.refBufferPowerDown))
		else $error("reference power mismatch");
	chk_ref_indep_pd: assert property (@(posedge core_clk) disable iff (rst)
		($changed(cfg.devicePowerDown) && $stable(cfg.referencePowerDown) &&
		$stable(cfg.refBufferPowerDown)) ##1 $stable(cfg.referencePowerDown)
		|=> $stable(power.referenceOn))
		else $error("reference follows power-down");
	chk_busy_end: assert property (@(posedge core_clk) disable iff (rst)
		(st.state == ST_STORE && pushReady) |=> !busy ##1 1'b1)
		else $error("busy not dropped at end");
	chk_busy_span: assert property (@(posedge core_clk) disable iff (rst)
		$fell(busy) |-> $past(st.state) == ST_STORE)
		else $error("busy fell before result stored");
endmodule : sap_converter
`default_nettype wire

// ==== testbench/sap_host_model.sv ====
// Host model: drives the port pins and reads the serial output bit.
// Assumes the serial bit is dataBus[0] and one shared core_clk.
`default_nettype none
module sap_host_model import sap_pkg::*; (
	input wire logic core_clk,
	input wire logic serialBit,
	output var sap_pins_t pins
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Pin drivers
	// ----
	// Serial clock idles low so no stray edge leaves a frame
	initial begin
		pins = PIN_RESET;
		pins.serialClk = 1'b0;
	end
	task automatic port(input logic cs, input logic rd);
		@(posedge core_clk);
		pins.chipSelectN <= cs;
		pins.readN <= rd;
	endtask : port
	// Held six cycles: the pin filter needs two equal samples in a row
	task automatic launch();
		@(posedge core_clk);
		pins.conversionStartN <= 1'b0;
		repeat (6) @(posedge core_clk);
		pins.conversionStartN <= 1'b1;
	endtask : launch
	// 125 ns link clock, unrelated in phase to core_clk
	task automatic readSerial(output logic [RESULT_W-1:0] w);
		w = '0;
		// Offset keeps every link edge clear of a core_clk edge
		#2;
		for (int i = 0; i < RESULT_W; i++) begin
			#62.5 pins.serialClk = 1'b1;
			w = {w[RESULT_W-2:0], serialBit};
			#62.5 pins.serialClk = 1'b0;
		end
	endtask : readSerial
endmodule : sap_host_model
`default_nettype wire

// ==== testbench/sar_adc_conversion_and_output_port_test.sv ====
// Self-checking bench of the converter control and output port.
// Assumes default BIT_WAIT of two cycles per bit and an 8-deep FIFO.
`default_nettype none
module sar_adc_conversion_and_output_port_test import sap_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	sap_pins_t pins;
	sap_cfg_t cfg = '0;
	logic comparatorHigh;
	logic busy;
	logic [RESULT_W-1:0] dataBus;
	logic [RESULT_W-1:0] dataBusOeN;
	sap_power_t power;
	logic [RESULT_W-1:0] target = '0;
	logic [IDX_W-1:0] bitIdx = LAST_BIT;
	logic phase = 1'b0;
	int seed = 32'h7D61;
	int miscompares = 0;
	int check_count = 0;
	always #5 core_clk = ~core_clk;
	// ----
	// Comparator: keeps the trial bit where the target has a one
	// ----
	assign comparatorHigh = (bitIdx <= LAST_BIT) ? target[bitIdx] : 1'b0;
	always @(posedge core_clk) begin
		if (busy !== 1'b1) begin
			bitIdx <= LAST_BIT;
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
			if (phase && bitIdx != 5'h00) bitIdx <= bitIdx - 5'h01;
		end
	end
	sap_converter u_dut (.core_clk(core_clk), .rst(rst), .pins(pins),
		.cfg(cfg), .comparatorHigh(comparatorHigh), .busy(busy),
		.dataBus(dataBus), .dataBusOeN(dataBusOeN), .power(power));
	// A released pin has no pull: the host then sees the inverse
	sap_host_model u_host (.core_clk(core_clk),
		.serialBit(dataBusOeN[0] ? ~dataBus[0] : dataBus[0]),
		.pins(pins));
	// ----
	// Checking and expectations
	// ----
	task automatic checkWord(input string what,
		input logic [RESULT_W-1:0] e, input logic [RESULT_W-1:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : checkWord
	function automatic logic [RESULT_W-1:0] expPart(
		input logic [RESULT_W-1:0] t, input logic [1:0] m,
		input logic bin, input int p);
		logic [RESULT_W-1:0] w;
		w = (bin || m == MODE_PAR18) ? t : {~t[17], t[16:0]};
		if (m == MODE_PAR16) return p == 0 ? {2'h0, w[17:2]} : {2'h0, w[1:0], 14'h0};
		if (m == MODE_PAR8) begin
			if (p == 0) return {10'h0, w[17:10]};
			return p == 1 ? {10'h0, w[9:2]} : {10'h0, w[1:0], 6'h00};
		end
		return w;
	endfunction : expPart
	task automatic complete_run();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	// Poke: a second start and power-down land mid-conversion
	task automatic convert(input logic [RESULT_W-1:0] t, input logic poke);
		target <= t;
		u_host.launch();
		if (poke) begin
			cfg.devicePowerDown <= 1'b1;
			repeat (2) @(posedge core_clk);
			u_host.launch();
		end
		repeat (20) @(posedge core_clk);
		checkWord("busy mid", 18'h00001, RESULT_W'(busy));
		cfg.devicePowerDown <= 1'b0;
	endtask : convert
	task automatic waitIdle();
		int n = 0;
		while (busy !== 1'b0 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		checkWord("busy end", '0, RESULT_W'(busy));
	endtask : waitIdle
	task automatic readPar(input logic [RESULT_W-1:0] t, input logic [1:0] m,
		input logic bin);
		logic [RESULT_W-1:0] mask;
		int parts;
		parts = m == MODE_PAR8 ? 3 : (m == MODE_PAR16 ? 2 : 1);
		mask = m == MODE_PAR8 ? 18'h000FF : (m == MODE_PAR16 ? 18'h0FFFF : 18'h3FFFF);
		for (int p = 0; p < parts; p++) begin
			u_host.port(1'b0, 1'b0);
			repeat (8) @(posedge core_clk);
			checkWord("drive", '0, dataBusOeN);
			checkWord("word", expPart(t, m, bin, p), dataBus & mask);
			u_host.port(1'b0, 1'b1);
			repeat (8) @(posedge core_clk);
			checkWord("release", '1, dataBusOeN);
		end
		u_host.port(1'b1, 1'b1);
	endtask : readPar
	// ----
	// Main sequence and watchdog
	// ----
	initial begin
		#500000;
		miscompares++;
		complete_run();
	end
	initial begin
		logic [RESULT_W-1:0] t;
		logic [RESULT_W-1:0] w;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		checkWord("idle oeN", '1, dataBusOeN);
		for (int i = 0; i < 8; i++) begin
			cfg.referencePowerDown <= i[0];
			cfg.refBufferPowerDown <= i[1];
			cfg.devicePowerDown <= i[2];
			repeat (3) @(posedge core_clk);
			checkWord("power", {15'h0, ~i[0], ~i[1], ~i[2]}, RESULT_W'(power));
		end
		cfg.devicePowerDown <= 1'b0;
		$display("power test done");
		// First result after the long idle gap is thrown away
		convert(18'h00000, 1'b0);
		waitIdle();
		for (int k = 0; k < 12; k++) begin
			t = k < 2 ? (k == 1 ? 18'h3FFFF : 18'h20000) : RESULT_W'($random(seed));
			cfg.interfaceSelect <= k[1:0];
			cfg.outputCodingSelect <= k[2];
			convert(t, k[0]);
			waitIdle();
			repeat (4) @(posedge core_clk);
			if (k[1:0] == MODE_SERIAL) begin
				u_host.port(1'b0, 1'b0);
				repeat (8) @(posedge core_clk);
				u_host.readSerial(w);
				checkWord("serial", expPart(t, MODE_SERIAL, k[2], 0), w);
				repeat (8) @(posedge core_clk);
				checkWord("serial tail", '0, dataBus);
				u_host.port(1'b1, 1'b0);
				repeat (8) @(posedge core_clk);
				checkWord("cs high", '1, dataBusOeN);
				u_host.port(1'b1, 1'b1);
			end else begin
				readPar(t, k[1:0], k[2]);
			end
		end
		$display("mode test done");
		cfg.interfaceSelect <= MODE_PAR18;
		u_host.port(1'b0, 1'b0);
		for (int k = 0; k < 8; k++) begin
			convert(18'h01000 + RESULT_W'(k), 1'b0);
			waitIdle();
		end
		t = RESULT_W'($random(seed));
		convert(t, 1'b0);
		repeat (40) @(posedge core_clk);
		checkWord("full busy", 18'h00001, RESULT_W'(busy));
		u_host.port(1'b0, 1'b1);
		waitIdle();
		repeat (20) @(posedge core_clk);
		readPar(t, MODE_PAR18, 1'b0);
		$display("buffer test done");
		complete_run();
	end
endmodule : sar_adc_conversion_and_output_port_test
`default_nettype wire
